/* design/link_regs_pkg.sv */
// constants for the self-identify status and upper iso channel mask registers
package link_regs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] SELF_IDENTIFY_STATUS_OFS = 8'h68;
  localparam logic [ADDR_W-1:0] ISO_RX_UPPER_MASK_SET_OFS = 8'h70;
  localparam logic [ADDR_W-1:0] ISO_RX_UPPER_MASK_CLEAR_OFS = 8'h74;
  localparam int FAULT_BIT = 31;
  localparam int GEN_LSB = 16;
  localparam int GEN_W = 8;
  localparam int COUNT_LSB = 2;
  localparam int COUNT_W = 9;
  localparam logic [DATA_W-1:0] STATUS_RSVD_BITS = 32'h7F00_F803;
  localparam logic [GEN_W-1:0] GEN_RESET = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 9'h000;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 9'h1FF;
  localparam logic [DATA_W-1:0] MASK_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;
  localparam int BUF_ALIGN_BITS = 11;

  typedef enum logic [0:0] {
    RX_IDLE = 1'b0,
    RX_ACTIVE = 1'b1
  } rx_state_e;

  function automatic logic is_mask_addr(input logic [ADDR_W-1:0] addr);
    is_mask_addr = (addr == ISO_RX_UPPER_MASK_SET_OFS) || (addr == ISO_RX_UPPER_MASK_CLEAR_OFS);
  endfunction : is_mask_addr
endpackage : link_regs_pkg

/* design/regfile_if.sv */
// carrier between the register front end and its two storage blocks
`timescale 1ns/100ps
`default_nettype none
interface regfile_if;
  import link_regs_pkg::*;
  logic set_wr;
  logic clr_wr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] mask;
  logic [DATA_W-1:0] status;
  logic receiving;

  modport hub (output set_wr, output clr_wr, output wdata, input mask, input status, input receiving);
  modport mask_side (input set_wr, input clr_wr, input wdata, output mask);
  modport track_side (output status, output receiving);
endinterface : regfile_if
`default_nettype wire

/* design/chan_mask.sv */
// upper isochronous receive channel mask with set and clear strobes
`timescale 1ns/100ps
`default_nettype none
module chan_mask
  import link_regs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  regfile_if.mask_side rf
);
  logic [DATA_W-1:0] mask_r;
  logic [DATA_W-1:0] mask_nxt;

  // set applied before clear so a one on both strobes ends cleared; the front end never raises both
  always_comb begin
    mask_nxt = mask_r;
    if (rf.set_wr) begin
      mask_nxt = mask_nxt | rf.wdata;
    end
    if (rf.clr_wr) begin
      mask_nxt = mask_nxt & ~rf.wdata;
    end
  end

  // reset value is arbitrary by contract; software programs every bit first
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_r <= MASK_RESET;
    end else if (ce) begin
      mask_r <= mask_nxt;
    end
  end

  assign rf.mask = mask_r;

  a_mask_set_bits: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && rf.set_wr && !rf.clr_wr) |=> (mask_r == ($past(mask_r) | $past(rf.wdata))))
    else $error("mask set write did not or-in the data");
  a_mask_clear_bits: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && rf.clr_wr && !rf.set_wr) |=> (mask_r == ($past(mask_r) & ~$past(rf.wdata))))
    else $error("mask clear write did not remove the bits");
  a_mask_holds: assert property (@(posedge ref_clk) disable iff (rst)
    (!rf.set_wr && !rf.clr_wr) |=> $stable(mask_r))
    else $error("mask changed without a write");
endmodule : chan_mask
`default_nettype wire

/* design/selfid_tracker.sv */
// self-identify phase tracking: fault flag, reset generation, quadlet count
`timescale 1ns/100ps
`default_nettype none
module selfid_tracker
  import link_regs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic bus_reset_det,
  input wire logic selfid_start,
  input wire logic quadlet_written,
  input wire logic selfid_done,
  input wire logic hw_fault,
  input wire logic host_write_err,
  regfile_if.track_side rf
);
  rx_state_e state_r;
  rx_state_e state_nxt;
  logic fault_flag_r;
  logic fault_flag_nxt;
  logic rx_err_r;
  logic rx_err_nxt;
  logic [GEN_W-1:0] gen_r;
  logic [GEN_W-1:0] gen_nxt;
  logic [COUNT_W-1:0] count_r;
  logic [COUNT_W-1:0] count_nxt;
  logic fault_now;

  assign fault_now = (hw_fault || host_write_err) && (state_r == RX_ACTIVE || selfid_start);

  always_comb begin
    state_nxt = state_r;
    fault_flag_nxt = fault_flag_r;
    rx_err_nxt = rx_err_r;
    gen_nxt = gen_r;
    count_nxt = count_r;
    if (bus_reset_det) begin
      gen_nxt = gen_r + 8'h01;
    end
    unique case (state_r)
      RX_IDLE: begin
        if (selfid_start) begin
          state_nxt = RX_ACTIVE;
          rx_err_nxt = 1'b0;
        end
      end
      RX_ACTIVE: begin
        if (selfid_done) begin
          state_nxt = RX_IDLE;
          // an error in the closing cycle still counts against this reception
          fault_flag_nxt = rx_err_r || fault_now;
        end
      end
    endcase
    if (fault_now) begin
      rx_err_nxt = 1'b1;
      fault_flag_nxt = 1'b1;
    end
    if (selfid_start) begin
      count_nxt = quadlet_written ? 9'h001 : COUNT_RESET;
    end else if (quadlet_written && count_r != COUNT_MAX) begin
      count_nxt = count_r + 9'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= RX_IDLE;
      fault_flag_r <= 1'b0;
      rx_err_r <= 1'b0;
      gen_r <= GEN_RESET;
      count_r <= COUNT_RESET;
    end else if (ce) begin
      state_r <= state_nxt;
      fault_flag_r <= fault_flag_nxt;
      rx_err_r <= rx_err_nxt;
      gen_r <= gen_nxt;
      count_r <= count_nxt;
    end
  end

  assign rf.status = {fault_flag_r, 7'h00, gen_r, 5'h00, count_r, 2'b00};
  assign rf.receiving = (state_r == RX_ACTIVE);

  a_gen_advances: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && bus_reset_det) |=> (gen_r == $past(gen_r) + 8'h01))
    else $error("generation did not advance on bus reset");
  a_gen_wraps: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && bus_reset_det && gen_r == 8'hFF) |=> (gen_r == 8'h00))
    else $error("generation did not wrap to zero");
  a_count_cleared: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && selfid_start && !quadlet_written) |=> (count_r == COUNT_RESET))
    else $error("quadlet count not cleared at reception start");
  a_count_step: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && !selfid_start && quadlet_written && count_r < COUNT_MAX) |=> (count_r == $past(count_r) + 9'h001))
    else $error("quadlet count did not step");
  a_fault_raised: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && state_r == RX_ACTIVE && (hw_fault || host_write_err)) |=> fault_flag_r)
    else $error("fault flag not raised");
  a_fault_cleared: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && state_r == RX_ACTIVE && selfid_done && !rx_err_r && !hw_fault && !host_write_err) |=> !fault_flag_r)
    else $error("fault flag not cleared after clean reception");
  c_gen_wrap: cover property (@(posedge ref_clk) disable iff (rst) ce && bus_reset_det && gen_r == 8'hFF);
  c_fault_then_clean: cover property (@(posedge ref_clk) disable iff (rst)
    fault_flag_r ##[1:50] !fault_flag_r);
endmodule : selfid_tracker
`default_nettype wire

/* design/selfid_status_iso_rx_mask.sv */
// register front end: self-identify status, upper iso mask, channel filter, buffer address
// Function
// - set the fault flag, bit 31, on any error during self-identify reception
// - buffer contents are invalid while the fault flag is set
// - clear the fault flag when a reception completes without error
// - hardware faults and host write failures both raise the fault flag
// - bump the 8-bit generation count, bits 23..16, on each bus reset
// - generation count wraps from 255 to zero
// - bits 10..2 report quadlets written to the buffer in the latest reception; a bus reset alone keeps the count
// - the count includes the header quadlet and every data quadlet
// - quadlet count returns to zero when a new reception starts
// - reserved status bits 30..24, 15..11, 1..0 read as zero
// - status register sits at 68h and is read-only to software
// - upper mask holds one enable per upper channel; only enabled channels accepted
// - mask written through set address 70h and clear address 74h
// - reading either mask address returns the mask contents
// - mask has no defined reset value; software programs it before use
// - mask bit n enables channel n plus 32
// - self-identify packets go to a host buffer on a 2K-byte boundary
`timescale 1ns/100ps
`default_nettype none
module selfid_status_iso_rx_mask
  import link_regs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic reg_valid,
  input wire logic reg_write,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_ack,
  input wire logic bus_reset_det,
  input wire logic selfid_start,
  input wire logic quadlet_written,
  input wire logic selfid_done,
  input wire logic hw_fault,
  input wire logic host_write_err,
  input wire logic [DATA_W-1:BUF_ALIGN_BITS] buffer_base,
  output logic [DATA_W-1:0] selfid_wr_addr,
  output logic selfid_buffer_valid,
  input wire logic iso_pkt_valid,
  input wire logic [5:0] iso_channel,
  output logic iso_accept,
  output logic [DATA_W-1:0] iso_rx_upper_mask
);
  regfile_if rf ();

  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic ack_r;
  logic ack_nxt;
  logic accept_r;
  logic accept_nxt;
  logic [DATA_W-1:0] wr_addr_r;
  logic [DATA_W-1:0] wr_addr_nxt;
  logic buf_valid_r;
  logic buf_valid_nxt;
  logic wr_take;
  logic rd_take;
  logic [4:0] chan_idx;

  chan_mask u_mask (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .rf(rf.mask_side)
  );

  selfid_tracker u_track (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .bus_reset_det(bus_reset_det),
    .selfid_start(selfid_start),
    .quadlet_written(quadlet_written),
    .selfid_done(selfid_done),
    .hw_fault(hw_fault),
    .host_write_err(host_write_err),
    .rf(rf.track_side)
  );

  assign wr_take = reg_valid && reg_write;
  assign rd_take = reg_valid && !reg_write;

  // writes to the status address and unmapped addresses are dropped
  assign rf.set_wr = ce && wr_take && (reg_addr == ISO_RX_UPPER_MASK_SET_OFS);
  assign rf.clr_wr = ce && wr_take && (reg_addr == ISO_RX_UPPER_MASK_CLEAR_OFS);
  assign rf.wdata = reg_wdata;

  assign chan_idx = iso_channel[4:0];

  always_comb begin
    rdata_nxt = rdata_r;
    ack_nxt = reg_valid;
    if (rd_take) begin
      if (reg_addr == SELF_IDENTIFY_STATUS_OFS) begin
        rdata_nxt = rf.status & ~STATUS_RSVD_BITS;
      end else if (is_mask_addr(reg_addr)) begin
        rdata_nxt = rf.mask;
      end else begin
        rdata_nxt = RDATA_RESET;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_r <= RDATA_RESET;
      ack_r <= 1'b0;
    end else if (ce) begin
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
    end
  end

  // lower channels belong to another mask, so they never hit here
  always_comb begin
    accept_nxt = iso_pkt_valid && iso_channel[5] && rf.mask[chan_idx];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      accept_r <= 1'b0;
    end else if (ce) begin
      accept_r <= accept_nxt;
    end
  end

  // next buffer slot: 2K base plus four bytes per stored quadlet; count tops out inside 2K
  always_comb begin
    wr_addr_nxt = {buffer_base, rf.status[COUNT_LSB+COUNT_W-1:COUNT_LSB], 2'b00};
    buf_valid_nxt = !rf.status[FAULT_BIT] && !rf.receiving;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_addr_r <= RDATA_RESET;
      buf_valid_r <= 1'b0;
    end else if (ce) begin
      wr_addr_r <= wr_addr_nxt;
      buf_valid_r <= buf_valid_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_ack = ack_r;
  assign iso_accept = accept_r;
  assign iso_rx_upper_mask = rf.mask;
  assign selfid_wr_addr = wr_addr_r;
  assign selfid_buffer_valid = buf_valid_r;

  a_status_readback: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && rd_take && reg_addr == SELF_IDENTIFY_STATUS_OFS) |=> (reg_ack && reg_rdata == $past(rf.status)))
    else $error("status read did not return the live status");
  a_mask_readback: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && rd_take && is_mask_addr(reg_addr)) |=> (reg_ack && reg_rdata == $past(rf.mask)))
    else $error("mask read did not return the mask");
  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && rd_take && reg_addr == SELF_IDENTIFY_STATUS_OFS) |=> ((reg_rdata & STATUS_RSVD_BITS) == 32'h0000_0000))
    else $error("reserved status bits read non-zero");
  a_status_readonly: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && wr_take && reg_addr == SELF_IDENTIFY_STATUS_OFS) |=> (rf.mask == $past(rf.mask)))
    else $error("status write reached the mask");
  a_iso_accept: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && iso_pkt_valid && iso_channel[5]) |=> (iso_accept == $past(rf.mask[chan_idx])))
    else $error("upper channel accept disagrees with mask");
  a_iso_lower_reject: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && iso_pkt_valid && !iso_channel[5]) |=> !iso_accept)
    else $error("lower channel accepted by upper mask");
  a_buf_invalid: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && rf.status[FAULT_BIT]) |=> !selfid_buffer_valid)
    else $error("buffer marked valid while fault flag set");
  a_buf_aligned: assert property (@(posedge ref_clk) disable iff (rst)
    ce |=> (selfid_wr_addr[DATA_W-1:BUF_ALIGN_BITS] == $past(buffer_base)))
    else $error("buffer address left its 2K window");
  a_ack_follows: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && reg_valid) |=> reg_ack)
    else $error("request not acknowledged next cycle");

  c_mask_set_read: cover property (@(posedge ref_clk) disable iff (rst)
    rf.set_wr ##[1:4] (rd_take && is_mask_addr(reg_addr)));
  c_iso_hit: cover property (@(posedge ref_clk) disable iff (rst) iso_accept);
  c_status_read: cover property (@(posedge ref_clk) disable iff (rst)
    rd_take && reg_addr == SELF_IDENTIFY_STATUS_OFS && rf.status[FAULT_BIT]);
endmodule : selfid_status_iso_rx_mask
`default_nettype wire

/* testbench/phy_model.sv */
// behavioural link-side source of self-identify and isochronous events
`timescale 1ns/100ps
`default_nettype none
module phy_model (
  input wire logic ref_clk,
  output logic bus_reset_det,
  output logic selfid_start,
  output logic quadlet_written,
  output logic selfid_done,
  output logic hw_fault,
  output logic host_write_err,
  output logic iso_pkt_valid,
  output logic [5:0] iso_channel
);
  initial begin
    {bus_reset_det, selfid_start, quadlet_written, selfid_done} = 4'h0;
    {hw_fault, host_write_err, iso_pkt_valid} = 3'h0;
    iso_channel = 6'h2A;
  end
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic bus_reset();
    tick();
    bus_reset_det = 1'b1;
    tick();
    bus_reset_det = 1'b0;
  endtask : bus_reset
  // header quadlet then data quadlets; fault rides on quadlet fault_at
  task automatic selfid_run(input int nq, input int fault_at, input logic use_host);
    bus_reset();
    selfid_start = 1'b1;
    tick();
    selfid_start = 1'b0;
    for (int i = 0; i < nq; i++) begin
      quadlet_written = 1'b1;
      hw_fault = (i == fault_at) && !use_host;
      host_write_err = (i == fault_at) && use_host;
      tick();
    end
    {quadlet_written, hw_fault, host_write_err} = 3'h0;
    selfid_done = 1'b1;
    tick();
    selfid_done = 1'b0;
    tick();
  endtask : selfid_run
  // channel line shows junk once the header is gone
  task automatic iso(input logic [5:0] ch);
    tick();
    iso_channel = ch;
    iso_pkt_valid = 1'b1;
    tick();
    iso_pkt_valid = 1'b0;
    iso_channel = ~ch;
  endtask : iso
endmodule : phy_model
`default_nettype wire

/* testbench/selfid_status_iso_rx_mask_test.sv */
// self-checking bench for the status and upper iso mask register block
`timescale 1ns/100ps
`default_nettype none
module selfid_status_iso_rx_mask_test;
  import link_regs_pkg::*;
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] exp;
  } row_s;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic reg_valid = 1'b0;
  logic reg_write = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 32'h0000_0000;
  logic [DATA_W-1:BUF_ALIGN_BITS] buffer_base = 21'h1ABCDE;
  logic [DATA_W-1:0] reg_rdata, selfid_wr_addr, iso_rx_upper_mask, rd;
  logic reg_ack, selfid_buffer_valid, iso_accept;
  logic bus_reset_det, selfid_start, quadlet_written, selfid_done, hw_fault, host_write_err;
  logic iso_pkt_valid;
  logic [5:0] iso_channel;
  logic [5:0] chans [5] = '{6'h3F, 6'h20, 6'h21, 6'h1F, 6'h00};
  logic acc_exp [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  int fail_count = 0;
  int comparisons = 0;
  row_s rows [13];

  always #2.5 ref_clk = ~ref_clk;

  selfid_status_iso_rx_mask dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .reg_valid(reg_valid),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .bus_reset_det(bus_reset_det), .selfid_start(selfid_start),
    .quadlet_written(quadlet_written), .selfid_done(selfid_done), .hw_fault(hw_fault),
    .host_write_err(host_write_err), .buffer_base(buffer_base), .selfid_wr_addr(selfid_wr_addr),
    .selfid_buffer_valid(selfid_buffer_valid), .iso_pkt_valid(iso_pkt_valid),
    .iso_channel(iso_channel), .iso_accept(iso_accept), .iso_rx_upper_mask(iso_rx_upper_mask));

  phy_model phy (.ref_clk(ref_clk), .bus_reset_det(bus_reset_det), .selfid_start(selfid_start),
    .quadlet_written(quadlet_written), .selfid_done(selfid_done), .hw_fault(hw_fault),
    .host_write_err(host_write_err), .iso_pkt_valid(iso_pkt_valid), .iso_channel(iso_channel));

  task automatic print_verdict();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // answer lands exactly one cycle after the request edge
  task automatic reg_op(input logic wr, input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data,
                        output logic [DATA_W-1:0] rdv);
    @(posedge ref_clk);
    #1;
    reg_valid = 1'b1;
    reg_write = wr;
    reg_addr = addr;
    reg_wdata = data;
    @(posedge ref_clk);
    #1;
    reg_valid = 1'b0;
    reg_addr = ~addr;
    reg_wdata = ~data;
    check({31'h0, reg_ack}, 32'h1);
    rdv = reg_rdata;
  endtask : reg_op

  function automatic logic [DATA_W-1:0] stat(input logic f, input logic [7:0] g, input logic [8:0] c);
    return {f, 7'h00, g, 5'h00, c, 2'h0};
  endfunction : stat

  task automatic read_status(input logic [DATA_W-1:0] exp);
    reg_op(1'b0, SELF_IDENTIFY_STATUS_OFS, 32'h0000_0000, rd);
    check(rd, exp);
  endtask : read_status

  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    $display("FAIL t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
    print_verdict();
  end

  initial begin
    rows[0] = '{1'b1, 8'h70, 32'hFFFF_FFFF, 32'h0};
    rows[1] = '{1'b0, 8'h70, 32'h0, 32'hFFFF_FFFF};
    rows[2] = '{1'b1, 8'h74, 32'h0000_FFFF, 32'h0};
    rows[3] = '{1'b0, 8'h74, 32'h0, 32'hFFFF_0000};
    rows[4] = '{1'b1, 8'h74, 32'h0000_0000, 32'h0};
    rows[5] = '{1'b0, 8'h70, 32'h0, 32'hFFFF_0000};
    rows[6] = '{1'b1, 8'h70, 32'h0000_0001, 32'h0};
    rows[7] = '{1'b0, 8'h74, 32'h0, 32'hFFFF_0001};
    rows[8] = '{1'b1, 8'h68, 32'hFFFF_FFFF, 32'h0};
    rows[9] = '{1'b0, 8'h68, 32'h0, 32'h0000_0000};
    rows[10] = '{1'b0, 8'h6C, 32'h0, 32'h0000_0000};
    rows[11] = '{1'b1, 8'h74, 32'h7FFF_FFFE, 32'h0};
    rows[12] = '{1'b0, 8'h70, 32'h0, 32'h8000_0001};
    repeat (20) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    foreach (rows[i]) begin
      reg_op(rows[i].wr, rows[i].addr, rows[i].data, rd);
      if (!rows[i].wr) check(rd, rows[i].exp);
    end
    check(iso_rx_upper_mask, 32'h8000_0001);
    $display("test mask rows done");
    foreach (chans[i]) begin
      phy.iso(chans[i]);
      check({31'h0, iso_accept}, {31'h0, acc_exp[i]});
    end
    $display("test iso filter done");
    // a clear write while the enable is low must leave every state bit alone
    @(posedge ref_clk);
    #1;
    ce = 1'b0;
    reg_valid = 1'b1;
    reg_write = 1'b1;
    reg_addr = ISO_RX_UPPER_MASK_CLEAR_OFS;
    reg_wdata = 32'hFFFF_FFFF;
    @(posedge ref_clk);
    #1;
    reg_valid = 1'b0;
    check(iso_rx_upper_mask, 32'h8000_0001);
    check({31'h0, reg_ack}, 32'h0);
    ce = 1'b1;
    $display("test clock enable hold done");
    phy.selfid_run(4, -1, 1'b0);
    read_status(stat(1'b0, 8'h01, 9'h004));
    check(selfid_wr_addr, {buffer_base, 9'h004, 2'h0});
    check({31'h0, selfid_buffer_valid}, 32'h1);
    phy.selfid_run(3, 1, 1'b0);
    read_status(stat(1'b1, 8'h02, 9'h003));
    check({31'h0, selfid_buffer_valid}, 32'h0);
    phy.selfid_run(2, 0, 1'b1);
    read_status(stat(1'b1, 8'h03, 9'h002));
    phy.selfid_run(5, -1, 1'b0);
    read_status(stat(1'b0, 8'h04, 9'h005));
    $display("test self-identify runs done");
    repeat (251) phy.bus_reset();
    read_status(stat(1'b0, 8'hFF, 9'h005));
    phy.bus_reset();
    read_status(stat(1'b0, 8'h00, 9'h005));
    $display("test generation wrap done");
    phy.selfid_run(1, -1, 1'b0);
    @(posedge ref_clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check(reg_rdata, 32'h0000_0000);
    check({30'h0, reg_ack, iso_accept}, 32'h0);
    rst = 1'b0;
    read_status(32'h0000_0000);
    check({31'h0, selfid_buffer_valid}, 32'h1);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule : selfid_status_iso_rx_mask_test
`default_nettype wire
